// ---- swrc_params.svh ----
// timing counts, bit positions and reset values for the sleep, wake and reset-cause block
// included by the flag, wake-detect and top design files of the block; definitions only
`ifndef SWRC_PARAMS_SVH
`define SWRC_PARAMS_SVH
`define SWRC_CLK_MHZ 100
`define SWRC_WDT_TIMEOUT_MS 18
`define SWRC_WDT_CYCLES (`SWRC_WDT_TIMEOUT_MS * 1000 * `SWRC_CLK_MHZ)
`define SWRC_RST_DELAY_US 10
`define SWRC_RST_DELAY_CYCLES (`SWRC_RST_DELAY_US * `SWRC_CLK_MHZ)
`define SWRC_STATUS_TIMEOUT_BIT 4
`define SWRC_STATUS_PWRDN_BIT 3
`define SWRC_STATUS_PWU_BIT 7
`define SWRC_WAKE_PINS 3
`define SWRC_GPIO_WIDTH 6
`define SWRC_CNT_W 32
`define SWRC_AXI_ADDR_W 8
`define SWRC_ADDR_STATUS 8'h00
`define SWRC_ADDR_CTRL 8'h04
`define SWRC_ADDR_IRQ_STATUS 8'h08
`define SWRC_ADDR_IRQ_MASK 8'h0c
`define SWRC_ADDR_WDT_COUNT 8'h10
`define SWRC_CTRL_RESET 2'h3
`endif

// ---- swrc_pkg.sv ----
// types shared by the sleep, wake and reset-cause block
// no imports; users write swrc_pkg::name
package swrc_pkg;
    typedef enum logic [1:0] {
        SWRC_RUN = 2'b00,
        SWRC_SLEEP = 2'b01,
        SWRC_DELAY = 2'b10
    } swrc_state_t;
    typedef enum logic [2:0] {
        SWRC_CAUSE_NONE = 3'b000,
        SWRC_CAUSE_WDT = 3'b001,
        SWRC_CAUSE_PINRST = 3'b010,
        SWRC_CAUSE_PIN = 3'b011
    } swrc_cause_t;
endpackage

// ---- swrc_ev_if.sv ----
// carries the reset-cause events from the controller to the flag module
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface swrc_ev_if;
    logic por_done;
    logic wdt_wake;
    logic wdt_run;
    logic pin_rst_wake;
    logic pin_rst_run;
    logic pin_wake;
    logic sleep_exec;
    logic timeout_flag;
    logic powerdown_flag;
    logic pin_wake_flag;
    modport ctrl (output por_done, wdt_wake, wdt_run, pin_rst_wake, pin_rst_run, pin_wake, sleep_exec,
        input timeout_flag, powerdown_flag, pin_wake_flag);
    modport flags (input por_done, wdt_wake, wdt_run, pin_rst_wake, pin_rst_run, pin_wake, sleep_exec,
        output timeout_flag, powerdown_flag, pin_wake_flag);
endinterface

// ---- swrc_flags.sv ----
// reset-cause flags: timeout, powerdown and pin-wake
// events arrive as one-cycle pulses, at most one of them per cycle
`timescale 1ns/1ps
`include "swrc_params.svh"
module swrc_flags (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // events and flags
    swrc_ev_if.flags ev
);
    logic tmo_f;
    logic pwrdn_f;
    logic pw_f;

    // flags hold between events; a pin pulse alone leaves them alone
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tmo_f <= 1'b1;
            pwrdn_f <= 1'b1;
            pw_f <= 1'b0;
        end else if (ev.por_done) begin
            tmo_f <= 1'b1;
            pwrdn_f <= 1'b1;
            pw_f <= 1'b0;
        end else if (ev.wdt_wake) begin
            tmo_f <= 1'b0;
            pwrdn_f <= 1'b0;
            pw_f <= 1'b0;
        end else if (ev.wdt_run) begin
            tmo_f <= 1'b0;
            pw_f <= 1'b0;
        end else if (ev.pin_rst_wake) begin
            tmo_f <= 1'b1;
            pwrdn_f <= 1'b0;
            pw_f <= 1'b0;
        end else if (ev.pin_rst_run) begin
            pw_f <= 1'b0;
        end else if (ev.pin_wake) begin
            tmo_f <= 1'b1;
            pwrdn_f <= 1'b0;
            pw_f <= 1'b1;
        end else if (ev.sleep_exec) begin
            tmo_f <= 1'b1;
            pwrdn_f <= 1'b0;
        end
    end

    assign ev.timeout_flag = tmo_f;
    assign ev.powerdown_flag = pwrdn_f;
    assign ev.pin_wake_flag = pw_f;

    property p_wdt_wake_flags;
        @(posedge clock) disable iff (!rstn)
        ev.wdt_wake |=> (!tmo_f && !pwrdn_f && !pw_f);
    endproperty
    a_wdt_wake_flags: assert property (p_wdt_wake_flags) else $error("wdt wake flags wrong");

    property p_wdt_run_flags;
        @(posedge clock) disable iff (!rstn)
        (ev.wdt_run && !ev.por_done && !ev.wdt_wake) |=> (!tmo_f && !pw_f && pwrdn_f == $past(pwrdn_f));
    endproperty
    a_wdt_run_flags: assert property (p_wdt_run_flags) else $error("wdt run flags wrong");

    property p_pin_rst_run;
        @(posedge clock) disable iff (!rstn)
        (ev.pin_rst_run && !ev.por_done && !ev.wdt_wake && !ev.wdt_run && !ev.pin_rst_wake)
            |=> (!pw_f && $stable(tmo_f) && $stable(pwrdn_f));
    endproperty
    a_pin_rst_run: assert property (p_pin_rst_run) else $error("pin reset changed flags");

    property p_hold;
        @(posedge clock) disable iff (!rstn)
        !(ev.por_done || ev.wdt_wake || ev.wdt_run || ev.pin_rst_wake || ev.pin_rst_run || ev.pin_wake
            || ev.sleep_exec) |=> ($stable(tmo_f) && $stable(pwrdn_f) && $stable(pw_f));
    endproperty
    a_hold: assert property (p_hold) else $error("flag changed without event");
endmodule

// ---- swrc_wake_det.sv ----
// wake-pin synchroniser and change detector against the last port read
// pins are asynchronous to clock
`timescale 1ns/1ps
`include "swrc_params.svh"
module swrc_wake_det (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // pins and control
    input wire logic [`SWRC_WAKE_PINS-1:0] pins,
    input wire logic capture,
    // result
    output logic [`SWRC_WAKE_PINS-1:0] pins_sync,
    output logic changed
);
    logic [`SWRC_WAKE_PINS-1:0] meta;
    logic [`SWRC_WAKE_PINS-1:0] last_read;

    // two stages per pin so compare sees a settled level
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            pins_sync <= '0;
        end else begin
            meta <= pins;
            pins_sync <= meta;
        end
    end

    // reference updated only by a port read, so a stale reference re-wakes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            last_read <= '0;
        end else if (capture) begin
            last_read <= pins_sync;
        end
    end

    assign changed = |(pins_sync ^ last_read);

    property p_changed;
        @(posedge clock) disable iff (!rstn)
        capture |=> (changed == (pins_sync != $past(pins_sync)));
    endproperty
    a_changed: assert property (p_changed) else $error("pin change missed");
endmodule

// ---- swrc_top.sv ----
// sleep and wake controller with reset-cause flags and an axi4-lite register port
// Notes on behaviour
// - watchdog wake from sleep leaves pin-wake, timeout and powerdown flags all zero
// - watchdog timeout while running clears pin-wake and timeout, keeps powerdown
// - reset-pin wake from sleep gives pin-wake 0, timeout 1, powerdown 0
// - power-up sets powerdown and timeout, clears pin-wake; sleep clears powerdown
// - reset pin while running clears pin-wake, keeps timeout and powerdown
// - pin-change wake gives pin-wake 1, timeout 1, powerdown 0
// - flags hold until a reset event or sleep entry; a bare pin pulse changes none
// - sleep clears running watchdog, sets timeout, clears powerdown, stops oscillator driver
// - during sleep every io pin keeps its prior drive or high impedance
// - watchdog reset never drives the reset pin low
// - sleep ends with a full reset on reset pin, watchdog or pin change
// - pin-wake flag marks a wake-pin change during sleep versus last port access
// - while asleep a pin differing from the last read value triggers wake
// - re-sleeping without reading after a pin wake wakes at once
// - watchdog counter cleared on every wake from sleep
// - watchdog wake starts the reset delay timer, holding the core in reset
// - reset pin while running loads status pattern 0-0u uuuu
// assumes the core pulses sleep_exec, clrwdt_exec and port_access from the same clock
`timescale 1ns/1ps
`include "swrc_params.svh"
module swrc_top #(
    parameter int unsigned WDT_CYCLES = `SWRC_WDT_CYCLES,
    parameter int unsigned DELAY_CYCLES = `SWRC_RST_DELAY_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // core interface
    input wire logic sleep_exec,
    input wire logic clrwdt_exec,
    input wire logic port_access,
    input wire logic [`SWRC_GPIO_WIDTH-1:0] core_gpio_out,
    input wire logic [`SWRC_GPIO_WIDTH-1:0] core_gpio_oe_n,
    output logic core_reset,
    output logic osc_drive_en,
    // pins
    input wire logic external_reset_pin,
    input wire logic wake_pin_0,
    input wire logic wake_pin_1,
    input wire logic wake_pin_3,
    output logic [`SWRC_GPIO_WIDTH-1:0] gpio_out,
    output logic [`SWRC_GPIO_WIDTH-1:0] gpio_oe_n,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    // configuration
    input wire logic reset_pin_enable,
    // axi4-lite slave
    input wire logic [`SWRC_AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SWRC_AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    output logic irq
);
    swrc_ev_if ev();
    swrc_pkg::swrc_state_t state;
    logic [`SWRC_CNT_W-1:0] watchdog_counter;
    logic [`SWRC_CNT_W-1:0] reset_delay_timer;
    logic [1:0] rp_sync;
    logic rp_low_d;
    logic [`SWRC_WAKE_PINS-1:0] pins_sync;
    logic pin_changed;
    logic [1:0] ctrl;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic wdt_enable;
    logic wake_on_change;
    logic wdt_expire;
    logic rp_fall;
    logic wake_any;
    logic [`SWRC_GPIO_WIDTH-1:0] held_out;
    logic [`SWRC_GPIO_WIDTH-1:0] held_oe_n;
    logic por_pending;
    logic delay_done;

    assign wdt_enable = ctrl[0];
    assign wake_on_change = ctrl[1];

    // reset pin passes two flops; only the second is read
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rp_sync <= 2'b11;
            rp_low_d <= 1'b0;
        end else begin
            rp_sync <= {rp_sync[0], external_reset_pin};
            rp_low_d <= ~rp_sync[1];
        end
    end

    assign rp_fall = reset_pin_enable && ~rp_sync[1] && ~rp_low_d;

    swrc_wake_det u_wake (
        .clock(clock),
        .rstn(rstn),
        .pins({wake_pin_3, wake_pin_1, wake_pin_0}),
        .capture(port_access),
        .pins_sync(pins_sync),
        .changed(pin_changed)
    );

    swrc_flags u_flags (
        .clock(clock),
        .rstn(rstn),
        .ev(ev.flags)
    );

    assign wdt_expire = wdt_enable && (watchdog_counter == WDT_CYCLES - 1);
    assign wake_any = (rp_fall || wdt_expire || (wake_on_change && pin_changed));

    // event pulses, one per cycle, pin reset highest priority
    always_comb begin
        ev.por_done = por_pending && (state == swrc_pkg::SWRC_DELAY) && delay_done;
        ev.wdt_wake = 1'b0;
        ev.wdt_run = 1'b0;
        ev.pin_rst_wake = 1'b0;
        ev.pin_rst_run = 1'b0;
        ev.pin_wake = 1'b0;
        ev.sleep_exec = 1'b0;
        if (state == swrc_pkg::SWRC_SLEEP) begin
            if (rp_fall) begin
                ev.pin_rst_wake = 1'b1;
            end else if (wdt_expire) begin
                ev.wdt_wake = 1'b1;
            end else if (wake_on_change && pin_changed) begin
                ev.pin_wake = 1'b1;
            end
        end else if (state == swrc_pkg::SWRC_RUN) begin
            if (rp_fall) begin
                ev.pin_rst_run = 1'b1;
            end else if (wdt_expire) begin
                ev.wdt_run = 1'b1;
            end else if (sleep_exec) begin
                ev.sleep_exec = 1'b1;
            end
        end
    end

    // state machine
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= swrc_pkg::SWRC_DELAY;
        end else begin
            case (state)
                swrc_pkg::SWRC_RUN: begin
                    if (rp_fall || wdt_expire) begin
                        state <= swrc_pkg::SWRC_DELAY;
                    end else if (sleep_exec) begin
                        state <= swrc_pkg::SWRC_SLEEP;
                    end
                end
                swrc_pkg::SWRC_SLEEP: begin
                    if (wake_any) begin
                        state <= swrc_pkg::SWRC_DELAY;
                    end
                end
                swrc_pkg::SWRC_DELAY: begin
                    if (delay_done) begin
                        state <= swrc_pkg::SWRC_RUN;
                    end
                end
                default: begin
                    state <= swrc_pkg::SWRC_DELAY;
                end
            endcase
        end
    end

    // reset delay counts only while the pin is released
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reset_delay_timer <= '0;
        end else if (state != swrc_pkg::SWRC_DELAY || (reset_pin_enable && ~rp_sync[1])) begin
            reset_delay_timer <= '0;
        end else if (reset_delay_timer != DELAY_CYCLES - 1) begin
            reset_delay_timer <= reset_delay_timer + 1'b1;
        end
    end

    // power-up is the first delay exit after reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            por_pending <= 1'b1;
        end else if (state == swrc_pkg::SWRC_RUN) begin
            por_pending <= 1'b0;
        end
    end
    // delay ends once the count is reached with the pin released
    assign delay_done = (reset_delay_timer == DELAY_CYCLES - 1) && !(reset_pin_enable && ~rp_sync[1]);

    // watchdog keeps running in sleep; cleared at sleep entry and every wake
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            watchdog_counter <= '0;
        end else if (!wdt_enable || clrwdt_exec || ev.sleep_exec || state == swrc_pkg::SWRC_DELAY) begin
            watchdog_counter <= '0;
        end else if (wdt_expire) begin
            watchdog_counter <= '0;
        end else begin
            watchdog_counter <= watchdog_counter + 1'b1;
        end
    end

    // io drive frozen at sleep entry
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            held_out <= '0;
            held_oe_n <= '1;
        end else if (state != swrc_pkg::SWRC_SLEEP && !ev.sleep_exec) begin
            held_out <= core_gpio_out;
            held_oe_n <= core_gpio_oe_n;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gpio_out <= '0;
            gpio_oe_n <= '1;
        end else if (state == swrc_pkg::SWRC_SLEEP || ev.sleep_exec) begin
            gpio_out <= held_out;
            gpio_oe_n <= held_oe_n;
        end else begin
            gpio_out <= core_gpio_out;
            gpio_oe_n <= core_gpio_oe_n;
        end
    end

    assign core_reset = (state == swrc_pkg::SWRC_DELAY);
    assign osc_drive_en = (state != swrc_pkg::SWRC_SLEEP);
    assign reset_pin_out = 1'b1;
    assign reset_pin_oe_n = 1'b1;

    // interrupt status: pin reset, watchdog, pin wake, sleep entry; set wins over clear
    logic [3:0] irq_set;
    logic wr_fire;
    logic [3:0] w1c;
    assign irq_set = {ev.sleep_exec, ev.pin_wake, ev.wdt_wake | ev.wdt_run, ev.pin_rst_wake | ev.pin_rst_run};
    assign w1c = (wr_fire && s_axi_awaddr == `SWRC_ADDR_IRQ_STATUS && s_axi_wstrb[0]) ? s_axi_wdata[3:0] : 4'h0;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~w1c) | irq_set;
        end
    end
    assign irq = |(irq_status & irq_mask);

    // axi4-lite write: address and data taken together
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready = s_axi_awready;
    assign wr_fire = s_axi_awready;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `SWRC_CTRL_RESET;
            irq_mask <= '0;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == `SWRC_ADDR_CTRL) begin
                ctrl <= s_axi_wdata[1:0];
            end else if (s_axi_awaddr == `SWRC_ADDR_IRQ_MASK) begin
                irq_mask <= s_axi_wdata[3:0];
            end
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr == `SWRC_ADDR_CTRL || s_axi_awaddr == `SWRC_ADDR_IRQ_MASK
                || s_axi_awaddr == `SWRC_ADDR_IRQ_STATUS) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read
    assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `SWRC_ADDR_STATUS: begin
                    s_axi_rdata <= 32'h0000_0000 | ({31'h0, ev.pin_wake_flag} << `SWRC_STATUS_PWU_BIT)
                        | ({31'h0, ev.timeout_flag} << `SWRC_STATUS_TIMEOUT_BIT)
                        | ({31'h0, ev.powerdown_flag} << `SWRC_STATUS_PWRDN_BIT);
                end
                `SWRC_ADDR_CTRL: s_axi_rdata <= {30'h0, ctrl};
                `SWRC_ADDR_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status};
                `SWRC_ADDR_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
                `SWRC_ADDR_WDT_COUNT: s_axi_rdata <= watchdog_counter;
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_sleep_osc_off;
        @(posedge clock) disable iff (!rstn)
        (state == swrc_pkg::SWRC_SLEEP) |-> !osc_drive_en;
    endproperty
    a_sleep_osc_off: assert property (p_sleep_osc_off) else $error("oscillator on in sleep");

    property p_io_hold;
        @(posedge clock) disable iff (!rstn)
        (state == swrc_pkg::SWRC_SLEEP && $past(state) == swrc_pkg::SWRC_SLEEP)
            |-> ($stable(gpio_out) && $stable(gpio_oe_n));
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("io changed in sleep");

    property p_no_pin_drive;
        @(posedge clock) disable iff (!rstn)
        reset_pin_oe_n;
    endproperty
    a_no_pin_drive: assert property (p_no_pin_drive) else $error("reset pin driven");

    property p_wake_reset;
        @(posedge clock) disable iff (!rstn)
        (state == swrc_pkg::SWRC_SLEEP && wake_any) |=> core_reset;
    endproperty
    a_wake_reset: assert property (p_wake_reset) else $error("wake without reset");

    property p_wdt_clear_wake;
        @(posedge clock) disable iff (!rstn)
        (state == swrc_pkg::SWRC_SLEEP && wake_any) |=> ##1 (watchdog_counter == 0);
    endproperty
    a_wdt_clear_wake: assert property (p_wdt_clear_wake) else $error("watchdog not cleared on wake");
endmodule

// ---- swrc_pins.sv ----
// partner model: external reset pin and the three wake pins
// driven from bench controls that change just after rising edges
`timescale 1ns/1ps
module swrc_pins (
    // control from the bench
    input wire logic clock,
    input wire logic rst_go,
    input wire logic [2:0] wake_val,
    // pins
    output logic external_reset_pin,
    output logic [2:0] wake_pins
);
    logic [3:0] low_cnt = 4'h0;
    // pulled up when idle; low long enough to pass the two-flop sync
    assign external_reset_pin = (low_cnt == 4'h0);
    assign wake_pins = wake_val;
    always @(posedge clock) begin
        if (rst_go) begin
            low_cnt <= 4'h6;
        end else if (low_cnt != 4'h0) begin
            low_cnt <= low_cnt - 4'h1;
        end
    end
endmodule

// ---- tb.sv ----
// bench for the sleep, wake and reset-cause block
// short watchdog and reset delay counts keep the run brief
`timescale 1ns/1ps
`include "swrc_params.svh"
module tb;
    logic clock, rstn, sleep_exec, clrwdt_exec, port_access, rst_go;
    logic [5:0] gpo, gpoe, gpio_out, gpio_oe_n;
    logic [2:0] wake_val, wpin;
    logic core_reset, osc_drive_en, xrst, rpo, rpoe, irq, rpen;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_val;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, resp;
    int fail_count = 0, comparisons = 0, cyc = 0;
    swrc_pins i_swrc_pins (.clock(clock), .rst_go(rst_go), .wake_val(wake_val),
        .external_reset_pin(xrst), .wake_pins(wpin));
    swrc_top #(.WDT_CYCLES(50), .DELAY_CYCLES(8)) i_swrc_top (.clock(clock), .rstn(rstn),
        .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec), .port_access(port_access),
        .core_gpio_out(gpo), .core_gpio_oe_n(gpoe), .core_reset(core_reset), .osc_drive_en(osc_drive_en),
        .external_reset_pin(xrst), .wake_pin_0(wpin[0]), .wake_pin_1(wpin[1]), .wake_pin_3(wpin[2]),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .reset_pin_out(rpo), .reset_pin_oe_n(rpoe),
        .reset_pin_enable(rpen), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ready is looked at on the falling edge, so the taking edge is the next rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge clock); while (!(awready && wready));
        @(posedge clock);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge clock); while (!bvalid);
        resp = bresp;
        @(posedge clock);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clock); while (!arready);
        @(posedge clock);
        arvalid <= 1'b0;
        do @(negedge clock); while (!rvalid);
        rd_val = rdata;
        resp = rresp;
        @(posedge clock);
        rready <= 1'b0;
    endtask
    task automatic go_sleep(input logic cap);
        @(posedge clock);
        port_access <= cap;
        @(posedge clock);
        port_access <= 1'b0;
        sleep_exec <= 1'b1;
        @(posedge clock);
        sleep_exec <= 1'b0;
    endtask
    task automatic pin_rst;
        @(posedge clock);
        rst_go <= 1'b1;
        @(posedge clock);
        rst_go <= 1'b0;
    endtask
    // waits out a device reset, then writes the given control word
    task automatic wake(input logic [31:0] c);
        while (core_reset !== 1'b1) @(negedge clock);
        while (core_reset !== 1'b0) @(negedge clock);
        wr(8'h04, c);
    endtask
    initial begin
        {rstn, sleep_exec, clrwdt_exec, port_access, rst_go, rpen} = 6'h01;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wake_val, gpo} = 'h0;
        gpoe = 6'h3f;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        while (core_reset !== 1'b0) @(negedge clock);
        rd(8'h00);
        chk(rd_val, 32'h0000_0018);
        rd(8'h04);
        chk(rd_val, 32'h0000_0003);
        rd(8'h20);
        chk(resp, 2'h2);
        wr(8'h20, 32'h0000_0001);
        chk(resp, 2'h2);
        $display("test power_up done");
        wake(32'h0000_0002);
        rd(8'h00);
        chk(rd_val, 32'h0000_0008);
        $display("test wdt_run done");
        wr(8'h0c, 32'h0000_0000);
        wr(8'h08, 32'h0000_000f);
        gpo <= 6'h2a;
        gpoe <= 6'h0f;
        go_sleep(1'b1);
        gpo <= 6'h15;
        gpoe <= 6'h30;
        repeat (3) @(negedge clock);
        chk(osc_drive_en, 1'b0);
        chk({gpio_out, gpio_oe_n}, 12'ha8f);
        @(posedge clock);
        wake_val <= 3'h1;
        wake(32'h0000_0002);
        rd(8'h00);
        chk(rd_val, 32'h0000_0090);
        go_sleep(1'b0);
        repeat (8) @(negedge clock);
        chk(core_reset, 1'b1);
        wake(32'h0000_0002);
        $display("test pin_wake done");
        wr(8'h08, 32'h0000_000f);
        pin_rst();
        wake(32'h0000_0002);
        rd(8'h00);
        chk(rd_val, 32'h0000_0010);
        rd(8'h08);
        chk(rd_val, 32'h0000_0001);
        chk(irq, 1'b0);
        wr(8'h0c, 32'h0000_0001);
        chk(irq, 1'b1);
        wr(8'h08, 32'h0000_0001);
        chk(irq, 1'b0);
        // a pin pulse with the reset function off must not reset the device
        @(posedge clock);
        rpen <= 1'b0;
        pin_rst();
        repeat (10) @(negedge clock);
        chk(core_reset, 1'b0);
        @(posedge clock);
        rpen <= 1'b1;
        $display("test pin_reset_run done");
        wr(8'h04, 32'h0000_0001);
        go_sleep(1'b1);
        while (core_reset !== 1'b1) @(negedge clock);
        chk({rpo, rpoe}, 2'h3);
        wake(32'h0000_0001);
        rd(8'h00);
        chk(rd_val, 32'h0000_0000);
        rd(8'h10);
        chk(rd_val < 32'h0000_001e, 1'b1);
        $display("test wdt_wake done");
        go_sleep(1'b1);
        pin_rst();
        wake(32'h0000_0002);
        rd(8'h00);
        chk(rd_val, 32'h0000_0010);
        $display("test pin_reset_wake done");
        final_report;
    end
endmodule
